// ==== core/afe_power_down_test_ctrl.v ====
// power-down and test-mode control of an eight-channel receive front end
// assumes one 100 MHz clock, AHB-Lite single word transfers, async pins
//
// Notes on behaviour
// [R1] each block's power-down is the OR of every request aimed at it
// [R2] shutdown pin covers all; sleep pins and bits cover amplifiers; stage bits own stage; in the code summing_buffer_on ignores the shutdown pin
// [R3] partial power-down turns amplifiers off and keeps references on
// [R4] partial power-down when quick-sleep pin or partial-sleep bit is set
// [R5] complete power-down when full-sleep bit or shutdown pin is set
// [R6] complete power-down also turns the references off
// [R7] register contents are kept during any power-down
// [R8] an eight-bit mask turns channels off one by one
// [R9] host turns attenuator and gain stages off with power_ctrl bit 10 in continuous-wave use
// [R10] test mode routes gain outputs of channels seven and eight to summing pins
// [R11] test_route_ctrl bit 9 set enables the gain test mode
// [R12] test_route_ctrl bit 8 powers the summing buffer on when one
// [R13] cw_buffer_gain_ctrl bits 4..0 pick feedback; 10h is internal 2k
// [R14] controller picks observation point via buffer power and gain field
// [R15] power-down takes effect within one microsecond of its request
// [R16] partial wake takes the larger of 2 us and 1% of sleep time
// [R17] mask bit n adds to the requests of channel n only
`timescale 1ns/100ps
`include "afe_pdn_defines.vh"
module afe_power_down_test_ctrl (
  input  wire        clock,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // power-down pins
  input  wire        chip_shutdown_pin,
  input  wire        quick_sleep_pin,
  // analog controls
  output reg  [7:0]  front_amplifier_off,
  output reg  [7:0]  atten_gain_off,
  output reg         reference_off,
  output reg         summing_buffer_on,
  output reg  [4:0]  summing_feedback_sel,
  output reg         test_route_ch7_ch8,
  output reg         partial_mode,
  output reg         complete_mode,
  output reg         waking
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function [31:0] byte_addr;
    input [7:0] idx;
    begin
      byte_addr = {22'h000000, idx, 2'b00};
    end
  endfunction

  function hit;
    input [31:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr == byte_addr(idx));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire shutdown_level;
  wire quick_level;

  pin_sync3 u_sync_shutdown (
    .clock (clock),
    .rst   (rst),
    .pin   (chip_shutdown_pin),
    .level (shutdown_level)
  );

  pin_sync3 u_sync_quick (
    .clock (clock),
    .rst   (rst),
    .pin   (quick_sleep_pin),
    .level (quick_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  reg         dp_valid;
  reg         dp_write;
  reg  [31:0] dp_addr;

  wire        take = hsel & htrans[1] & hready;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 32'h00000000;
    end else if (hready) begin
      dp_valid <= take;
      dp_write <= take & hwrite;
      dp_addr  <= haddr;
    end
  end

  // zero wait state, always OKAY
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; only the bus writes them, power-down never clears them

  reg  [15:0] cw_buffer_gain_ctrl;
  reg  [15:0] test_route_ctrl;
  reg  [15:0] power_ctrl;

  wire        wr = dp_valid & dp_write;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cw_buffer_gain_ctrl <= `RST_CW_BUFFER_GAIN_CTRL;
      test_route_ctrl     <= `RST_TEST_ROUTE_CTRL;
      power_ctrl          <= `RST_POWER_CTRL;
    end else if (wr) begin                                // see [R7]
      if (hit(dp_addr, `IDX_CW_BUFFER_GAIN_CTRL)) begin
        cw_buffer_gain_ctrl <= hwdata[15:0];
      end
      if (hit(dp_addr, `IDX_TEST_ROUTE_CTRL)) begin
        test_route_ctrl <= hwdata[15:0];
      end
      if (hit(dp_addr, `IDX_POWER_CTRL)) begin
        power_ctrl <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request combination

  wire       partial_sleep_bit        = power_ctrl[`PARTIAL_SLEEP_BIT];
  wire       full_sleep_bit           = power_ctrl[`FULL_SLEEP_BIT];
  wire       atten_gain_stage_off_bit = power_ctrl[`ATTEN_GAIN_OFF_BIT];
  wire       front_amp_off_bit        = power_ctrl[`FRONT_AMP_OFF_BIT];
  wire [7:0] channel_off_mask         = power_ctrl[`MASK_MSB:`MASK_LSB]; // see [R8]

  wire next_partial  = quick_level | partial_sleep_bit;    // see [R4]
  wire next_complete = shutdown_level | full_sleep_bit;    // see [R5]
  // amplifiers fall to any sleep request
  wire amp_sleep     = next_complete | next_partial;       // see [R2] see [R3]

  wire [7:0] next_front_off  = {8{amp_sleep | front_amp_off_bit}} |
                               channel_off_mask;           // see [R1] see [R17]
  wire [7:0] next_atten_off  = {8{amp_sleep | atten_gain_stage_off_bit}} |
                               channel_off_mask;           // see [R1] see [R17]

  wire wake_busy;

  wake_timer u_wake (
    .clock  (clock),
    .rst    (rst),
    .asleep (amp_sleep),
    .waking (wake_busy)
  );

  // one cycle after the synchronisers, well inside the limit (see [R15])
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      front_amplifier_off <= 8'h00;
      atten_gain_off      <= 8'h00;
      reference_off       <= 1'b0;
      partial_mode        <= 1'b0;
      complete_mode       <= 1'b0;
      waking              <= 1'b0;
    end else begin
      front_amplifier_off <= next_front_off;                // see [R15]
      atten_gain_off      <= next_atten_off;                // see [R15]
      reference_off       <= next_complete;                 // see [R6] see [R3]
      partial_mode        <= next_partial & ~next_complete;
      complete_mode       <= next_complete;
      waking              <= wake_busy;                     // see [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test routing and summing buffer

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      test_route_ch7_ch8   <= 1'b0;
      summing_buffer_on    <= 1'b0;
      summing_feedback_sel <= 5'h00;
    end else begin
      test_route_ch7_ch8   <= test_route_ctrl[`TEST_EN_BIT];    // see [R11] see [R10]
      summing_buffer_on    <= test_route_ctrl[`SUM_BUF_ON_BIT]; // see [R12]
      summing_feedback_sel <= cw_buffer_gain_ctrl[`GAIN_MSB:`GAIN_LSB]; // see [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, prepared in the address phase

  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (hit(haddr, `IDX_CW_BUFFER_GAIN_CTRL)) begin
      next_rdata = {16'h0000, cw_buffer_gain_ctrl};
    end else if (hit(haddr, `IDX_TEST_ROUTE_CTRL)) begin
      next_rdata = {16'h0000, test_route_ctrl};
    end else if (hit(haddr, `IDX_POWER_CTRL)) begin
      next_rdata = {16'h0000, power_ctrl};
    end else if (hit(haddr, `IDX_POWER_STATUS)) begin
      next_rdata[`ST_PARTIAL_BIT]  = partial_mode;
      next_rdata[`ST_COMPLETE_BIT] = complete_mode;
      next_rdata[`ST_WAKING_BIT]   = waking;
      next_rdata[`ST_TEST_BIT]     = test_route_ch7_ch8;
    end
  end

  // a read right behind a write to the same register sees the new word
  wire fwd = wr & (dp_addr == haddr) &
             (hit(haddr, `IDX_CW_BUFFER_GAIN_CTRL) | hit(haddr, `IDX_TEST_ROUTE_CTRL) |
              hit(haddr, `IDX_POWER_CTRL));

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      hrdata <= fwd ? {16'h0000, hwdata[15:0]} : next_rdata;
    end
  end

endmodule

// ==== core/afe_pdn_defines.vh ====
// constants of the power-down and test-mode controller
// assumes a 100 MHz clock and a 32-bit AHB-Lite register bus
`ifndef AFE_PDN_DEFINES_VH
`define AFE_PDN_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CW_BUFFER_GAIN_CTRL 8'h36
`define IDX_TEST_ROUTE_CTRL     8'h3b
`define IDX_POWER_CTRL          8'h40
`define IDX_POWER_STATUS        8'h41

// reset values
`define RST_CW_BUFFER_GAIN_CTRL 16'h0000
`define RST_TEST_ROUTE_CTRL     16'h0000
`define RST_POWER_CTRL          16'h0000

// test_route_ctrl fields
`define TEST_EN_BIT             9
`define SUM_BUF_ON_BIT          8
// cw_buffer_gain_ctrl field
`define GAIN_LSB                0
`define GAIN_MSB                4
`define GAIN_INT_2K             5'h10

// power_ctrl fields
`define MASK_LSB                0
`define MASK_MSB                7
`define PARTIAL_SLEEP_BIT       8
`define FULL_SLEEP_BIT          9
`define ATTEN_GAIN_OFF_BIT      10
`define FRONT_AMP_OFF_BIT       11

// power_status fields
`define ST_PARTIAL_BIT          0
`define ST_COMPLETE_BIT         1
`define ST_WAKING_BIT           2
`define ST_TEST_BIT             3

// timing
`define CLK_PERIOD_NS           10
`define PDN_MAX_NS              1000
`define PDN_MAX_CYC             (`PDN_MAX_NS / `CLK_PERIOD_NS)
`define WAKE_MIN_NS             2000
`define WAKE_MIN_CYC            ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_PCT_DIV            100
`define WAKE_CREDIT_W           20

`endif

// ==== core/pin_sync3.v ====
// three-stage synchroniser for one asynchronous pin
// output changes once the second and third stages agree
`timescale 1ns/100ps
module pin_sync3 (
  input  wire clock,
  input  wire rst,
  input  wire pin,
  output reg  level
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// ==== core/wake_timer.v ====
// wake-up timer for the partial and complete power-down
// asleep is a level on the same clock; waking is high during the wake time
`timescale 1ns/100ps
`include "afe_pdn_defines.vh"
module wake_timer (
  input  wire clock,
  input  wire rst,
  input  wire asleep,
  output reg  waking
);
  reg  [6:0]                  prescale;
  reg  [`WAKE_CREDIT_W-1:0]   credit;
  reg  [`WAKE_CREDIT_W-1:0]   remain;
  reg                         asleep_d;
  wire [31:0]                 min_full = `WAKE_MIN_CYC;
  wire [31:0]                 pct_last = `WAKE_PCT_DIV - 1;
  wire [`WAKE_CREDIT_W-1:0]   min_cyc  = min_full[`WAKE_CREDIT_W-1:0];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale <= 7'h00;
      credit   <= {`WAKE_CREDIT_W{1'b0}};
      remain   <= {`WAKE_CREDIT_W{1'b0}};
      asleep_d <= 1'b0;
      waking   <= 1'b0;
    end else begin
      asleep_d <= asleep;
      if (asleep) begin
        waking <= 1'b0;
        remain <= {`WAKE_CREDIT_W{1'b0}};
        // one credit cycle per hundred cycles asleep, saturating
        if (prescale == pct_last[6:0]) begin
          prescale <= 7'h00;
          if (~&credit) begin
            credit <= credit + 1'b1;
          end
        end else begin
          prescale <= prescale + 7'h01;
        end
      end else if (asleep_d) begin
        // larger of the minimum and one percent of the sleep time (see [R16])
        remain   <= (credit > min_cyc) ? credit - 1'b1 : min_cyc - 1'b1;
        waking   <= 1'b1;
        credit   <= {`WAKE_CREDIT_W{1'b0}};
        prescale <= 7'h00;
      end else if (remain != {`WAKE_CREDIT_W{1'b0}}) begin
        remain <= remain - 1'b1;
      end else begin
        waking <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/host_pin_model.sv ====
// host side model driving the two power-down pins
// assumes requests from the bench change just after a rising edge
`timescale 1ns/100ps
module host_pin_model (
  input  wire  clock,
  input  wire  rst,
  input  wire  want_shutdown,
  input  wire  want_quick,
  output logic chip_shutdown_pin,
  output logic quick_sleep_pin
);
  // push-pull pins, low while in reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      chip_shutdown_pin <= 1'b0;
      quick_sleep_pin   <= 1'b0;
    end else begin
      chip_shutdown_pin <= want_shutdown;
      quick_sleep_pin   <= want_quick;
    end
  end
endmodule

// ==== bench/afe_pdn_asserts.sv ====
// concurrent checks on the ports of the power-down controller
// assumes one clock domain and hready tied to hreadyout
`timescale 1ns/100ps
`include "afe_pdn_defines.vh"
module afe_pdn_asserts (
  input wire       clock,
  input wire       rst,
  input wire       hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hready,
  input wire       chip_shutdown_pin,
  input wire       quick_sleep_pin,
  input wire [7:0] front_amplifier_off,
  input wire [7:0] atten_gain_off,
  input wire       reference_off,
  input wire       summing_buffer_on,
  input wire [4:0] summing_feedback_sel,
  input wire       test_route_ch7_ch8,
  input wire       partial_mode,
  input wire       complete_mode,
  input wire       waking
);
  localparam [31:0] GAIN_A  = `IDX_CW_BUFFER_GAIN_CTRL * 4;
  localparam [31:0] ROUTE_A = `IDX_TEST_ROUTE_CTRL * 4;
  wire        wr = hsel && htrans[1] && hready && hwrite;
  logic [11:0] wake_len;
  // length of the current wake interval
  always @(posedge clock or posedge rst) begin
    if (rst) wake_len <= 12'h000;
    else if (waking) wake_len <= wake_len + 12'h001;
    else wake_len <= 12'h000;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_ref_complete: assert property (reference_off == complete_mode)
    else $error("reference power differs from complete mode");
  chk_partial_refs: assert property (partial_mode |-> !reference_off)
    else $error("references off in partial mode");
  chk_complete_off: assert property (complete_mode |->
    (front_amplifier_off & atten_gain_off) == 8'hff)
    else $error("amplifier left on in complete mode");
  chk_partial_off: assert property (partial_mode |->
    front_amplifier_off == 8'hff && atten_gain_off == 8'hff)
    else $error("amplifier left on in partial mode");
  chk_shutdown_delay: assert property (chip_shutdown_pin [*8] |->
    complete_mode)
    else $error("shutdown pin not obeyed in time");
  chk_quick_delay: assert property (quick_sleep_pin [*8] |->
    partial_mode || complete_mode)
    else $error("quick sleep pin not obeyed in time");
  chk_wake_length: assert property ($fell(waking) && !partial_mode && !complete_mode
    |-> wake_len >= 12'd199)
    else $error("wake interval too short");
  chk_gain_by_write: assert property ($changed(summing_feedback_sel) |->
    $past(wr && haddr == GAIN_A, 3))
    else $error("feedback select changed without a write");
  chk_route_by_write: assert property ($changed({test_route_ch7_ch8, summing_buffer_on})
    |-> $past(wr && haddr == ROUTE_A, 3))
    else $error("test routing changed without a write");
  cover property ($rose(waking));
  cover property ($fell(waking) && wake_len > 12'd200);
  cover property ($rose(test_route_ch7_ch8));
  cover property (partial_mode && !complete_mode);
endmodule

// ==== bench/tb_afe_power_down_test_ctrl.sv ====
// self-checking bench for the power-down and test-mode controller
// assumes a 100 MHz clock and a single-slave AHB-Lite bus
`timescale 1ns/100ps
`include "afe_pdn_defines.vh"
module tb_afe_power_down_test_ctrl;
  logic        clock, rst, hsel, hwrite, want_shutdown, want_quick;
  logic [31:0] haddr, hwdata, rd, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hreadyout, hresp, reference_off, summing_buffer_on, test_route_ch7_ch8;
  wire         partial_mode, complete_mode, waking, chip_shutdown_pin, quick_sleep_pin;
  wire  [31:0] hrdata;
  wire  [7:0]  front_amplifier_off, atten_gain_off;
  wire  [4:0]  summing_feedback_sel;
  int          errors, checks_done, cycles;
  localparam [31:0] GAIN_A  = `IDX_CW_BUFFER_GAIN_CTRL * 4;
  localparam [31:0] ROUTE_A = `IDX_TEST_ROUTE_CTRL * 4;
  localparam [31:0] PWR_A   = `IDX_POWER_CTRL * 4;
  localparam [31:0] STAT_A  = `IDX_POWER_STATUS * 4;
  localparam [31:0] NONE_A  = 32'h0000_0200;
  afe_power_down_test_ctrl afe_power_down_test_ctrl_i (.clock, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .chip_shutdown_pin, .quick_sleep_pin, .front_amplifier_off, .atten_gain_off,
    .reference_off, .summing_buffer_on, .summing_feedback_sel, .test_route_ch7_ch8,
    .partial_mode, .complete_mode, .waking);
  host_pin_model host_pin_model_i (.clock, .rst, .want_shutdown, .want_quick,
    .chip_shutdown_pin, .quick_sleep_pin);
  ////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask
  function logic [31:0] reg_addr(input int i);
    case (i)
      0: return GAIN_A;
      1: return ROUTE_A;
      2: return PWR_A;
      3: return STAT_A;
      default: return NONE_A;
    endcase
  endfunction
  function logic [7:0] exp_off(input logic [31:0] p, input logic stage);
    return (p[8] | p[9] | stage) ? 8'hff : p[7:0];
  endfunction
  // larger of the minimum wake time and one percent of the time asleep
  function int wake_cycles(input int asleep);
    return (asleep / `WAKE_PCT_DIV > `WAKE_MIN_CYC) ? asleep / `WAKE_PCT_DIV : `WAKE_MIN_CYC;
  endfunction
  task results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    want_shutdown = 1'b0;
    want_quick = 1'b0;
    d = $urandom(32'h5a25bb28);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, reg_addr(i), 32'h0);
      check(rd, 32'h0);
    end
    $display("test reset values done");
    bus(1'b1, ROUTE_A, 32'h200);
    repeat (4) begin
      d = $urandom;
      bus(1'b1, ROUTE_A, d);
      bus(1'b1, GAIN_A, ~d);
      bus(1'b1, NONE_A, d);
      bus(1'b1, STAT_A, d);
      bus(1'b0, ROUTE_A, 32'h0);
      check(rd, d & 32'hffff);
      bus(1'b0, GAIN_A, 32'h0);
      check(rd, ~d & 32'hffff);
      bus(1'b0, NONE_A, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, STAT_A, 32'h0);
      check(rd, {28'h0, d[9], 3'b000});
      check({test_route_ch7_ch8, summing_buffer_on, summing_feedback_sel},
            {d[9:8], ~d[4:0]});
    end
    bus(1'b1, ROUTE_A, 32'h300);
    bus(1'b1, GAIN_A, 32'h10);
    $display("test registers done");
    for (int n = 0; n < 11; n++) begin
      // n 8 powers the attenuator and gain stages down for continuous-wave use
      d = n < 8 ? 32'h1 << n : n == 8 ? 32'h400 : n == 9 ? 32'h800 : $urandom & 32'hff;
      bus(1'b1, PWR_A, d);
      repeat (3) @(posedge clock);
      check(front_amplifier_off, exp_off(d, d[11]));
      check(atten_gain_off, exp_off(d, d[10]));
    end
    $display("test channel mask done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, PWR_A, k == 1 ? 32'h100 : k == 2 ? 32'h200 : 32'h0);
      want_quick <= k == 0;
      want_shutdown <= k == 3;
      repeat (100) @(posedge clock);
      check({partial_mode, complete_mode, reference_off},
            {k < 2, k > 1, k > 1});
      check({front_amplifier_off, atten_gain_off}, 16'hffff);
      bus(1'b0, STAT_A, 32'h0);
      check(rd, {28'h0, 2'b10, k > 1, k < 2});
      bus(1'b0, GAIN_A, 32'h0);
      check(rd, 32'h10);
      want_quick <= 1'b0;
      want_shutdown <= 1'b0;
      bus(1'b1, PWR_A, 32'h0);
      repeat (20) @(posedge clock);
      check(waking, 1'b1);
      repeat (250) @(posedge clock);
      check(waking, 1'b0);
    end
    $display("test sleep modes done");
    // long sleep: the wake time follows the sleep time, not the minimum
    bus(1'b1, PWR_A, 32'h200);
    repeat (25000) @(posedge clock);
    bus(1'b1, PWR_A, 32'h0);
    repeat (240) @(posedge clock);
    check(waking, wake_cycles(25000) > 240);
    repeat (40) @(posedge clock);
    check(waking, wake_cycles(25000) > 280);
    $display("test long wake done");
    results();
  end
endmodule
bind afe_power_down_test_ctrl afe_pdn_asserts afe_pdn_asserts_i (.clock, .rst, .hsel,
  .haddr, .htrans, .hwrite, .hready, .chip_shutdown_pin, .quick_sleep_pin,
  .front_amplifier_off, .atten_gain_off, .reference_off, .summing_buffer_on,
  .summing_feedback_sel, .test_route_ch7_ch8, .partial_mode, .complete_mode, .waking);
